// ===== rtl/fts_defs.svh
// Purpose: Constants for the failure transfer and self-tune supervisor.
// Assumes: APB register access, one 125 MHz clock.
// Notes: Offsets are byte addresses of aligned 32-bit words.
`ifndef FTS_DEFS_SVH
`define FTS_DEFS_SVH

`define FTS_CFG_OFS      8'h00
`define FTS_PCT_OFS      8'h04
`define FTS_STAT_OFS     8'h08
`define FTS_PID_OFS      8'h0C
`define FTS_PID_LAST     8'h20

`define FTS_CFG_RST      20'h0_0000
`define FTS_PCT_RST      10'h000
`define FTS_PID_RST      16'h0000
`define FTS_PCT_MAX      10'h3E8

// Field positions of the configuration register; FTS_F_PCT2 sits in the word at FTS_PCT_OFS.
`define FTS_F_RNG1       0
`define FTS_F_RNG2       2
`define FTS_F_USE1       4
`define FTS_F_USE2       5
`define FTS_F_DIRECT     6
`define FTS_F_COOLING_FUNCTION       7
`define FTS_F_HOLD1      8
`define FTS_F_HOLD2      9
`define FTS_F_A1ST       10
`define FTS_F_A2ST       11
`define FTS_F_ALARM_ONE_FUNCTION       12
`define FTS_F_ALARM_TWO_FUNCTION       14
`define FTS_F_MANUAL     16
`define FTS_F_CALIB      17
`define FTS_F_SLEEP      18
`define FTS_F_SELF       19
`define FTS_F_PCT2       16

// Low-signal thresholds in microamps and millivolts.
`define FTS_CUR_MIN_UA   16'h03E8
`define FTS_VOLT_MIN_MV  16'h00FA

`define FTS_CLK_MHZ      125
`define FTS_POWERUP_MS   2500
`define FTS_POWERUP_CYC  (`FTS_POWERUP_MS * `FTS_CLK_MHZ * 1000)
`define FTS_AVG_US       10
`define FTS_AVG_CYC      (`FTS_AVG_US * `FTS_CLK_MHZ)

`endif

// ===== rtl/fts_pkg.sv
// Purpose: Types for the failure transfer and self-tune supervisor.
// Assumes: Constants come from fts_defs.svh.
// Notes: None.
package fts_pkg;

	typedef enum logic [1:0] {
		FTS_RNG_OTHER = 2'b00,
		FTS_RNG_MA    = 2'b01,
		FTS_RNG_VOLT  = 2'b10
	} fts_range_t;

	typedef enum logic [1:0] {
		FTS_AFN_OTHER = 2'b00,
		FTS_AFN_LOOP  = 2'b01,
		FTS_AFN_SENSOR_BREAK_FUNCTION  = 2'b10,
		FTS_AFN_TIMER = 2'b11
	} fts_afn_t;

	typedef enum logic {
		FTS_PH_START = 1'b0,
		FTS_PH_RUN   = 1'b1
	} fts_phase_t;

endpackage : fts_pkg

// ===== rtl/fts_top.sv
// Purpose: Failure detection, output and alarm transfer, self-tune gating.
// Assumes: Inputs synchronous to CLK_SYS; values in tenths of a percent.
// Notes: Tuning search and alarm trigger logic sit outside this block.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "fts_defs.svh"
module fts_top
	import fts_pkg::*;
#(
	parameter int unsigned POWERUP_CYC = `FTS_POWERUP_CYC
)(
	input  wire logic        CLK_SYS,     // System clock.
	input  wire logic        RST,         // Asynchronous reset, high.
	input  wire logic        PSEL,        // APB select.
	input  wire logic        PENABLE,     // APB enable.
	input  wire logic        PWRITE,      // APB direction.
	input  wire logic [7:0]  PADDR,       // APB byte address.
	input  wire logic [31:0] PWDATA,      // APB write data.
	output logic      [31:0] PRDATA,      // APB read data.
	output logic             PREADY,      // APB ready.
	output logic             PSLVERR,     // APB error.
	input  wire logic        IN1_OPEN,    // Input one open.
	input  wire logic [15:0] IN1_LEVEL,   // Input one in uA or mV.
	input  wire logic        IN2_OPEN,    // Input two open.
	input  wire logic [15:0] IN2_LEVEL,   // Input two in uA or mV.
	input  wire logic        ADC_FAIL,    // Converter failed.
	input  wire logic        LOOP_BREAK,  // Loop break seen.
	input  wire logic        EVENT_IN,    // Selects parameter set two.
	input  wire logic [9:0]  MV1_IN,      // First manipulated value.
	input  wire logic [9:0]  MV2_IN,      // Second manipulated value.
	input  wire logic        ALM1_IN,     // Alarm one from trigger logic.
	input  wire logic        ALM2_IN,     // Alarm two from trigger logic.
	input  wire logic        ST_STEP,     // Self-tune step done, pulse.
	input  wire logic        ST_BETTER,   // Step improved control.
	input  wire logic        ST_DONE,     // Self-tune optimum, pulse.
	input  wire logic        AT_DONE,     // Auto-tune result, pulse.
	input  wire logic [15:0] TUNE_PB,     // Tuned band.
	input  wire logic [15:0] TUNE_TI,     // Tuned integral time.
	input  wire logic [15:0] TUNE_TD,     // Tuned derivative time.
	output logic      [9:0]  OUT1_VAL,    // Output one level.
	output logic             OUT1_ON,     // Output one on-off state.
	output logic      [9:0]  OUT_TWO_FUNCTION_SELECT_VAL,    // Output two level.
	output logic             ALM1_OUT,    // Alarm one drive.
	output logic             ALM2_OUT,    // Alarm two drive.
	output logic             FAIL_OUT,    // Failure mode.
	output logic             XFER_OUT,    // Transfer active.
	output logic             ST_ENABLE,   // Self-tune running.
	output logic             ST_DIR,      // Step direction.
	output logic             ST_SEED      // Restart from seed, pulse.
);

	typedef struct packed {
		logic [19:0]       cfg;
		logic [9:0]        pct1;
		logic [9:0]        pct2;
		logic [5:0][15:0]  pid;
		logic [31:0]       pu_cnt;
		fts_phase_t        phase;
		logic [10:0]       div;
		logic [13:0]       avg1;
		logic [13:0]       avg2;
		logic              brk1;
		logic              brk2;
		logic              adcf;
		logic              fail;
		logic              xfer;
		logic              sten;
		logic              dir;
		logic              seed;
		logic [9:0]        out1;
		logic              out1_on;
		logic [9:0]        out_two_function_select;
		logic              alm1;
		logic              alm2;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} fts_state_t;

	fts_state_t state_reg;
	fts_state_t state_next;

	logic              wr_en;
	logic              rd_en;
	logic              wr_take;
	logic [2:0]        pid_idx;
	logic              pid_hit;
	logic              raw1;
	logic              raw2;
	logic              fail_now;
	logic              xfer_now;
	logic [2:0]        set_base;
	logic [15:0]       pb_act;
	logic [15:0]       ti_act;
	logic              st_ok;
	logic              avg_tick;
	logic [14:0]       diff1;
	logic [14:0]       diff2;
	logic [9:0]        hold1;
	logic [9:0]        hold2;
	logic [9:0]        fix1;
	logic [9:0]        fix2;
	logic [31:0]       status;
	fts_range_t        rng1;
	fts_range_t        rng2;
	fts_afn_t          afn1;
	fts_afn_t          afn2;

	// Break detection per input, gated by use of that input as a source.
	function automatic logic brk_of(
		input fts_range_t  rng,
		input logic        open,
		input logic [15:0] lvl
	);
		logic b;
		b = open;
		if (rng == FTS_RNG_MA && lvl < `FTS_CUR_MIN_UA)
		begin
			b = 1'b1;
		end
		if (rng == FTS_RNG_VOLT && lvl < `FTS_VOLT_MIN_MV)
		begin
			b = 1'b1;
		end
		return b;
	endfunction : brk_of

	// Alarm drive: dwell timer passes through, break kinds force on.
	function automatic logic alm_of(
		input fts_afn_t fn,
		input logic     fail,
		input logic     preset,
		input logic     live
	);
		logic a;
		a = live;
		if (fail && fn != FTS_AFN_TIMER)
		begin
			if (fn == FTS_AFN_LOOP || fn == FTS_AFN_SENSOR_BREAK_FUNCTION)
			begin
				a = 1'b1;
			end
			else
			begin
				a = preset;
			end
		end
		return a;
	endfunction : alm_of

	function automatic logic [9:0] clamp_pct(input logic [9:0] v);
		return (v > `FTS_PCT_MAX) ? `FTS_PCT_MAX : v;
	endfunction : clamp_pct

	always_comb
	begin
		wr_en    = PSEL & PENABLE & PWRITE & ~state_reg.pready;
		rd_en    = PSEL & PENABLE & ~PWRITE & ~state_reg.pready;
		wr_take  = PSEL & PENABLE & PWRITE & state_reg.pready;
		pid_hit  = (PADDR >= `FTS_PID_OFS) && (PADDR <= `FTS_PID_LAST)
			&& (PADDR[1:0] == 2'b00);
		pid_idx  = 3'(PADDR[7:2] - 6'(`FTS_PID_OFS >> 2));
		rng1     = fts_range_t'(state_reg.cfg[`FTS_F_RNG1 +: 2]);
		rng2     = fts_range_t'(state_reg.cfg[`FTS_F_RNG2 +: 2]);
		afn1     = fts_afn_t'(state_reg.cfg[`FTS_F_ALARM_ONE_FUNCTION +: 2]);
		afn2     = fts_afn_t'(state_reg.cfg[`FTS_F_ALARM_TWO_FUNCTION +: 2]);
		raw1     = state_reg.cfg[`FTS_F_USE1]
			& brk_of(rng1, IN1_OPEN, IN1_LEVEL);
		raw2     = state_reg.cfg[`FTS_F_USE2]
			& brk_of(rng2, IN2_OPEN, IN2_LEVEL);
		fail_now = raw1 | raw2 | ADC_FAIL;
		xfer_now = (state_reg.phase == FTS_PH_START) | fail_now
			| state_reg.cfg[`FTS_F_MANUAL]
			| state_reg.cfg[`FTS_F_CALIB];
		set_base = EVENT_IN ? 3'd3 : 3'd0;
		pb_act   = state_reg.pid[set_base];
		ti_act   = state_reg.pid[3'(set_base + 3'd1)];
		st_ok    = state_reg.cfg[`FTS_F_SELF]
			& (pb_act != `FTS_PID_RST) & (ti_act != `FTS_PID_RST)
			& ~LOOP_BREAK & ~fail_now
			& ~state_reg.cfg[`FTS_F_MANUAL]
			& ~state_reg.cfg[`FTS_F_SLEEP]
			& ~state_reg.cfg[`FTS_F_CALIB];
		avg_tick = (state_reg.div == 11'(`FTS_AVG_CYC - 1));
		diff1    = {1'b0, MV1_IN, 4'h0} - {1'b0, state_reg.avg1};
		diff2    = {1'b0, MV2_IN, 4'h0} - {1'b0, state_reg.avg2};
		hold1    = state_reg.avg1[13:4];
		hold2    = state_reg.avg2[13:4];
		fix1     = clamp_pct(state_reg.pct1);
		fix2     = clamp_pct(state_reg.pct2);
		status   = {24'h00_0000, state_reg.dir, state_reg.phase == FTS_PH_START,
			state_reg.sten, state_reg.xfer, state_reg.fail,
			state_reg.adcf, state_reg.brk2, state_reg.brk1};
	end

	always_comb
	begin
		state_next = state_reg;

		if (state_reg.phase == FTS_PH_START)
		begin
			if (state_reg.pu_cnt == POWERUP_CYC - 1)
			begin
				state_next.phase = FTS_PH_RUN;
			end
			else
			begin
				state_next.pu_cnt = state_reg.pu_cnt + 32'h0000_0001;
			end
		end

		state_next.div = avg_tick ? 11'h000 : 11'(state_reg.div + 11'h001);
		// The averages freeze while transfer is active, so they hold the value
		// seen just before activation.
		if (avg_tick && !xfer_now)
		begin
			state_next.avg1 = 14'(state_reg.avg1
				+ 14'(15'($signed(diff1) >>> 4)));
			state_next.avg2 = 14'(state_reg.avg2
				+ 14'(15'($signed(diff2) >>> 4)));
		end

		state_next.brk1 = raw1;
		state_next.brk2 = raw2;
		state_next.adcf = ADC_FAIL;
		state_next.fail = fail_now;
		state_next.xfer = xfer_now;

		if (!xfer_now)
		begin
			state_next.out1    = MV1_IN;
			state_next.out1_on = (MV1_IN != 10'h000);
		end
		else if (pb_act == `FTS_PID_RST)
		begin
			state_next.out1_on = state_reg.cfg[`FTS_F_DIRECT];
			state_next.out1    = state_reg.cfg[`FTS_F_DIRECT]
				? `FTS_PCT_MAX : 10'h000;
		end
		else if (state_reg.cfg[`FTS_F_HOLD1])
		begin
			state_next.out1    = hold1;
			state_next.out1_on = (hold1 != 10'h000);
		end
		else
		begin
			state_next.out1    = fix1;
			state_next.out1_on = (fix1 != 10'h000);
		end

		if (!xfer_now || !state_reg.cfg[`FTS_F_COOLING_FUNCTION])
		begin
			state_next.out_two_function_select = MV2_IN;
		end
		else if (state_reg.cfg[`FTS_F_HOLD2])
		begin
			state_next.out_two_function_select = hold2;
		end
		else
		begin
			state_next.out_two_function_select = fix2;
		end

		state_next.alm1 = alm_of(afn1, fail_now,
			state_reg.cfg[`FTS_F_A1ST], ALM1_IN);
		state_next.alm2 = alm_of(afn2, fail_now,
			state_reg.cfg[`FTS_F_A2ST], ALM2_IN);

		state_next.sten = st_ok;
		state_next.seed = 1'b0;
		if (state_reg.sten && ST_STEP && !ST_BETTER)
		begin
			state_next.dir = ~state_reg.dir;
		end

		state_next.pready  = PSEL & PENABLE & ~state_reg.pready;
		state_next.pslverr = 1'b0;
		state_next.prdata  = 32'h0000_0000;
		if (rd_en)
		begin
			case (PADDR)
				`FTS_CFG_OFS:
				begin
					state_next.prdata = {12'h000, state_reg.cfg};
				end
				`FTS_PCT_OFS:
				begin
					state_next.prdata = {6'h00, state_reg.pct2,
						6'h00, state_reg.pct1};
				end
				`FTS_STAT_OFS:
				begin
					state_next.prdata = status;
				end
				default:
				begin
					if (pid_hit)
					begin
						state_next.prdata = {16'h0000, state_reg.pid[pid_idx]};
					end
					else
					begin
						state_next.pslverr = 1'b1;
					end
				end
			endcase
		end
		// Refused writes are flagged in the first access cycle so the error
		// stands with PREADY; accepted writes land at the ready edge.
		if (wr_en && !(PADDR == `FTS_CFG_OFS || PADDR == `FTS_PCT_OFS || pid_hit))
		begin
			state_next.pslverr = 1'b1;
		end
		if (wr_take)
		begin
			case (PADDR)
				`FTS_CFG_OFS:
				begin
					state_next.cfg = PWDATA[19:0];
				end
				`FTS_PCT_OFS:
				begin
					state_next.pct1 = PWDATA[9:0];
					state_next.pct2 = PWDATA[`FTS_F_PCT2 +: 10];
				end
				default:
				begin
					if (pid_hit)
					begin
						state_next.pid[pid_idx] = PWDATA[15:0];
					end
				end
			endcase
		end

		// Hardware results come after software writes so they win a clash.
		if (state_reg.sten && (ST_DONE || AT_DONE))
		begin
			state_next.pid[set_base]              = TUNE_PB;
			state_next.pid[3'(set_base + 3'd1)]   = TUNE_TI;
			state_next.pid[3'(set_base + 3'd2)]   = TUNE_TD;
		end
		if (state_reg.sten && AT_DONE)
		begin
			state_next.seed = 1'b1;
		end
		if (state_reg.sten && ST_DONE)
		begin
			state_next.cfg[`FTS_F_SELF] = 1'b0;
			state_next.sten = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			state_reg        <= '0;
			state_reg.cfg    <= `FTS_CFG_RST;
			state_reg.pct1   <= `FTS_PCT_RST;
			state_reg.pct2   <= `FTS_PCT_RST;
			state_reg.phase  <= FTS_PH_START;
			state_reg.xfer   <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign PRDATA    = state_reg.prdata;
	assign PREADY    = state_reg.pready;
	assign PSLVERR   = state_reg.pslverr;
	assign OUT1_VAL  = state_reg.out1;
	assign OUT1_ON   = state_reg.out1_on;
	assign OUT_TWO_FUNCTION_SELECT_VAL  = state_reg.out_two_function_select;
	assign ALM1_OUT  = state_reg.alm1;
	assign ALM2_OUT  = state_reg.alm2;
	assign FAIL_OUT  = state_reg.fail;
	assign XFER_OUT  = state_reg.xfer;
	assign ST_ENABLE = state_reg.sten;
	assign ST_DIR    = state_reg.dir;
	assign ST_SEED   = state_reg.seed;

endmodule : fts_top

// ===== bench/fts_monitor.sv
// Purpose: Port-level checks of the failure transfer supervisor.
// Assumes: Bound to fts_top; one clock domain, reset high.
// Notes: Power-start length follows the bound parameter.
`timescale 1ns/100ps
module fts_monitor
#(
	parameter int unsigned POWERUP_CYC = 50
)(
	input wire logic       CLK_SYS,    // Clock.
	input wire logic       RST,        // Reset.
	input wire logic       PSEL,       // APB select.
	input wire logic       PENABLE,    // APB enable.
	input wire logic       PREADY,     // APB ready.
	input wire logic       ADC_FAIL,   // Converter failed.
	input wire logic       LOOP_BREAK, // Loop break.
	input wire logic       ST_STEP,    // Tune step.
	input wire logic       ST_BETTER,  // Step improved.
	input wire logic       ST_DONE,    // Tune optimum.
	input wire logic       AT_DONE,    // Auto-tune result.
	input wire logic [9:0] OUT1_VAL,   // Output one.
	input wire logic       FAIL_OUT,   // Failure mode.
	input wire logic       XFER_OUT,   // Transfer active.
	input wire logic       ST_ENABLE,  // Self-tune on.
	input wire logic       ST_DIR,     // Step direction.
	input wire logic       ST_SEED     // Seed pulse.
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	logic [31:0] up_reg;
	logic [31:0] up_next;
	// Counts edges since reset release and saturates.
	always_comb up_next = (up_reg == 32'hFFFF_FFFF) ? up_reg : up_reg + 32'h0000_0001;
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			up_reg <= 32'h0000_0000;
		else
			up_reg <= up_next;
	end
	sequence s_apb_req;
		PSEL && PENABLE && !PREADY;
	endsequence
	sequence s_seed_req;
		AT_DONE && ST_ENABLE;
	endsequence
	chk_apb_answer: assert property (s_apb_req |=> PREADY)
		else $error("APB access not answered after one wait state");
	chk_power_start: assert property (up_reg < POWERUP_CYC - 1 |-> XFER_OUT)
		else $error("transfer dropped during power start");
	chk_adc_fail: assert property (ADC_FAIL |=> FAIL_OUT && XFER_OUT)
		else $error("converter fault did not enter failure transfer");
	chk_fail_xfer: assert property (FAIL_OUT && $past(FAIL_OUT) |-> XFER_OUT)
		else $error("failure mode without output transfer");
	chk_tune_stop: assert property (ADC_FAIL || LOOP_BREAK |=> !ST_ENABLE)
		else $error("self-tune kept running on fault");
	chk_done_stop: assert property (ST_DONE && ST_ENABLE |=> !ST_ENABLE)
		else $error("self-tune not ended at optimum");
	chk_seed_pulse: assert property (s_seed_req |=> ST_SEED ##1 !ST_SEED)
		else $error("auto-tune result did not seed once");
	chk_dir_keep: assert property (ST_STEP && ST_BETTER && ST_ENABLE |=> $stable(ST_DIR))
		else $error("direction changed after better step");
	chk_dir_turn: assert property (ST_STEP && !ST_BETTER && ST_ENABLE
		|=> ST_DIR != $past(ST_DIR))
		else $error("direction kept after worse step");
	chk_open_loop: assert property (XFER_OUT && $past(XFER_OUT) && !$past(PSEL)
		&& !$past(PSEL, 2) |-> $stable(OUT1_VAL))
		else $error("output one moved during transfer");
endmodule : fts_monitor

bind fts_top fts_monitor #(.POWERUP_CYC(POWERUP_CYC)) u_mon (.*);

// ===== bench/fts_field.sv
// Purpose: Tuning engine on the far side, issuing step and result pulses.
// Assumes: Requests come from the bench one cycle wide.
// Notes: Tuned values are garbage outside a pulse.
`timescale 1ns/100ps
module fts_field (
	input wire logic        clk,      // Clock.
	input wire logic        rst,      // Reset.
	input wire logic [1:0]  kind,     // 1 step, 2 optimum, 3 auto result.
	input wire logic [47:0] vals,     // Band, integral, derivative.
	output logic            step_pls, // Step done.
	output logic            done_pls, // Optimum found.
	output logic            at_pls,   // Auto-tune result.
	output logic [47:0]     tune      // Tuned values.
);
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			{at_pls, done_pls, step_pls} <= 3'h0;
			tune <= 48'h0000_0000_0000;
		end
		else
		begin
			{at_pls, done_pls, step_pls} <= {kind == 2'h3, kind == 2'h2, kind == 2'h1};
			tune <= (kind != 2'h0) ? vals : ~tune;
		end
	end
endmodule : fts_field

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the failure transfer supervisor.
// Assumes: Short power-start count; APB through one task.
// Notes: Expected values come from a small integer model.
`timescale 1ns/100ps
`include "fts_defs.svh"
module tb_top;
	import fts_pkg::*;
	localparam int unsigned PUC = 50;
	logic CLK_SYS = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rd, seed = 32'hAF6E_6FD5;
	logic PREADY, PSLVERR, er, IN1_OPEN = 1'b0, IN2_OPEN = 1'b0, ADC_FAIL = 1'b0;
	logic [15:0] IN1_LEVEL = 16'h0FA0, IN2_LEVEL = 16'h0FA0, TUNE_PB, TUNE_TI, TUNE_TD;
	logic LOOP_BREAK = 1'b0, EVENT_IN = 1'b0, ALM1_IN = 1'b0, ALM2_IN = 1'b0;
	logic [9:0] MV1_IN = 10'h2BC, MV2_IN = 10'h12C, OUT1_VAL, OUT_TWO_FUNCTION_SELECT_VAL;
	logic ST_BETTER = 1'b0, ST_STEP, ST_DONE, AT_DONE, OUT1_ON, ALM1_OUT, ALM2_OUT;
	logic FAIL_OUT, XFER_OUT, ST_ENABLE, ST_DIR, ST_SEED, dir = 1'b0;
	logic [1:0] kind = 2'h0;
	logic [47:0] vals = 48'h0000_0000_0000;
	int failures = 0, n_checks = 0, cfg, p1, p2, a1, a2, av1 = 0, av2 = 0, cyc = 0;
	logic [47:0] tune_w;
	always #4 CLK_SYS = ~CLK_SYS;
	fts_top #(.POWERUP_CYC(PUC)) dut (.*);
	fts_field u_fld (.clk(CLK_SYS), .rst(RST), .kind(kind), .vals(vals), .step_pls(ST_STEP),
		.done_pls(ST_DONE), .at_pls(AT_DONE), .tune(tune_w));
	assign {TUNE_PB, TUNE_TI, TUNE_TD} = tune_w;
	// Counts clock edges since reset release, for the average tick model.
	always @(posedge CLK_SYS) cyc <= RST ? 0 : cyc + 1;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic ea(input int f, input logic st, input logic i);
		return (f == 3) ? i : ((f == 1 || f == 2) ? 1'b1 : st);
	endfunction : ea
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do
		begin
			@(negedge CLK_SYS);
			n++;
		end
		while (PREADY !== 1'b1 && n < 50);
		rd = PRDATA;
		er = PSLVERR;
		if (n >= 50)
			failures++;
		@(posedge CLK_SYS);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic wt();
		repeat (3) @(posedge CLK_SYS);
		@(negedge CLK_SYS);
	endtask : wt
	task automatic fld(input logic [1:0] k);
		@(posedge CLK_SYS);
		kind <= k;
		@(posedge CLK_SYS);
		kind <= 2'h0;
		wt();
	endtask : fld
	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (20000) @(posedge CLK_SYS);
		failures++;
		give_verdict();
	end
	initial
	begin
		repeat (4) @(posedge CLK_SYS);
		RST <= 1'b0;
		@(negedge CLK_SYS);
		chk(XFER_OUT, 1'b1);
		apb(1'b1, `FTS_PID_OFS, 32'h0000_0064);
		apb(1'b1, `FTS_PID_OFS + 8'h04, 32'h0000_0032);
		apb(1'b1, `FTS_CFG_OFS, 32'h0000_0100);
		apb(1'b0, `FTS_CFG_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0100);
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk({er, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, `FTS_STAT_OFS, 32'hFFFF_FFFF);
		chk(er, 1'b1);
		wt();
		chk({XFER_OUT, OUT1_VAL}, 32'h0000_0400);
		repeat (PUC) @(posedge CLK_SYS);
		wt();
		chk({XFER_OUT, OUT1_VAL}, 32'h0000_02BC);
		// Two average ticks pass with transfer off; manual mode then holds them.
		apb(1'b1, `FTS_CFG_OFS, 32'h0000_0380);
		while (cyc < 2600)
			@(posedge CLK_SYS);
		repeat (2)
		begin
			av1 = av1 + ((16 * int'(MV1_IN) - av1) >>> 4);
			av2 = av2 + ((16 * int'(MV2_IN) - av2) >>> 4);
		end
		apb(1'b1, `FTS_CFG_OFS, 32'h0001_0380);
		wt();
		chk({XFER_OUT, OUT1_VAL}, 32'h0000_0400 | (av1 >> 4));
		chk(OUT_TWO_FUNCTION_SELECT_VAL, av2 >> 4);
		@(posedge CLK_SYS);
		MV1_IN <= 10'h123;
		MV2_IN <= 10'h045;
		wt();
		chk({OUT1_VAL, OUT_TWO_FUNCTION_SELECT_VAL}, ((av1 >> 4) << 10) | (av2 >> 4));
		for (int i = 0; i < 3; i++)
		begin
			p1 = xs() % 1001;
			p2 = xs() % 1001;
			cfg = 32'h0000_00B9 | (xs() & 32'h0000_0C00);
			apb(1'b1, `FTS_CFG_OFS, cfg);
			apb(1'b1, `FTS_PCT_OFS, p1 | (p2 << 16));
			IN1_LEVEL <= `FTS_CUR_MIN_UA;
			IN2_LEVEL <= `FTS_VOLT_MIN_MV;
			wt();
			chk(FAIL_OUT, 1'b0);
			@(posedge CLK_SYS);
			IN1_LEVEL <= (i == 0) ? `FTS_CUR_MIN_UA - 16'h0001 : 16'h0FA0;
			IN2_LEVEL <= (i == 1) ? `FTS_VOLT_MIN_MV - 16'h0001 : 16'h0FA0;
			ADC_FAIL <= (i == 2);
			wt();
			chk({FAIL_OUT, XFER_OUT}, 2'h3);
			chk(OUT1_VAL, p1);
			chk(OUT_TWO_FUNCTION_SELECT_VAL, p2);
			chk({ALM1_OUT, ALM2_OUT}, {cfg[10], cfg[11]});
			apb(1'b0, `FTS_STAT_OFS, 32'h0000_0000);
			chk(rd[2:0], 3'h1 << i);
			IN1_LEVEL <= 16'h0FA0;
			IN2_LEVEL <= 16'h0FA0;
			ADC_FAIL <= 1'b0;
			wt();
			chk(FAIL_OUT, 1'b0);
		end
		apb(1'b1, `FTS_PID_OFS, 32'h0000_0000);
		ADC_FAIL <= 1'b1;
		for (int d = 0; d < 2; d++)
		begin
			apb(1'b1, `FTS_CFG_OFS, 32'h0000_00B9 | (d << 6));
			wt();
			chk(OUT1_ON, d);
		end
		for (int k = 0; k < 8; k++)
		begin
			cfg = 32'h0000_00B9 | ((k & 3) << 12) | ((3 - (k & 3)) << 14) | (xs() & 32'h0000_0C00);
			a1 = xs() & 1;
			a2 = xs() & 1;
			@(posedge CLK_SYS);
			ALM1_IN <= a1[0];
			ALM2_IN <= a2[0];
			apb(1'b1, `FTS_CFG_OFS, cfg);
			wt();
			chk(ALM1_OUT, ea(k & 3, cfg[10], a1[0]));
			chk(ALM2_OUT, ea(3 - (k & 3), cfg[11], a2[0]));
		end
		@(posedge CLK_SYS);
		ADC_FAIL <= 1'b0;
		EVENT_IN <= 1'b1;
		apb(1'b1, 8'h18, 32'h0000_00C8);
		apb(1'b1, 8'h1C, 32'h0000_001E);
		apb(1'b1, `FTS_CFG_OFS, 32'h0008_00B9);
		wt();
		chk(ST_ENABLE, 1'b1);
		for (int s = 0; s < 4; s++)
		begin
			@(posedge CLK_SYS);
			ST_BETTER <= s[0];
			fld(2'h1);
			dir = dir ^ !s[0];
			chk(ST_DIR, dir);
		end
		for (int t = 0; t < 2; t++)
		begin
			@(posedge CLK_SYS);
			vals <= {xs() | 32'h0001_0001, 16'(xs())};
			fld(t ? 2'h2 : 2'h3);
			chk(ST_ENABLE, !t);
			apb(1'b0, 8'h18, 32'h0000_0000);
			chk(rd, vals[47:32]);
			apb(1'b0, 8'h1C, 32'h0000_0000);
			chk(rd, vals[31:16]);
			apb(1'b0, `FTS_PID_LAST, 32'h0000_0000);
			chk(rd, vals[15:0]);
		end
		apb(1'b0, `FTS_CFG_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_00B9);
		for (int c = 0; c < 5; c++)
		begin
			apb(1'b1, `FTS_CFG_OFS, 32'h0008_00B9);
			wt();
			chk(ST_ENABLE, 1'b1);
			@(posedge CLK_SYS);
			LOOP_BREAK <= (c == 3);
			cfg = (c == 4) ? 32'h0000_00B9 : 32'h0008_00B9 | ((c < 3) ? 32'h0001_0000 << c : 0);
			apb(1'b1, `FTS_CFG_OFS, cfg);
			wt();
			chk(ST_ENABLE, 1'b0);
			if (c < 2)
				chk(XFER_OUT, 1'b1);
			@(posedge CLK_SYS);
			LOOP_BREAK <= 1'b0;
		end
		give_verdict();
	end
endmodule : tb_top
